// file: arsc_pkg.sv
// Package for the converter result and single-scan block.
// Assumes a 32-bit AXI4-Lite register bus.
package arsc_pkg;
  // ------------------------------------------------------------
  // Register indices and byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_RESULT_LOW = 8'h2E;
  localparam logic [7:0] IDX_RESULT_HIGH = 8'h2F;
  localparam logic [9:0] ADDR_RESULT_LOW = {IDX_RESULT_LOW, 2'b00};
  localparam logic [9:0] ADDR_RESULT_HIGH = {IDX_RESULT_HIGH, 2'b00};
  localparam logic [9:0] ADDR_CONTROL = 10'h000;
  localparam logic [9:0] ADDR_IRQ_STATUS = 10'h004;
  localparam logic [9:0] ADDR_IRQ_MASK = 10'h008;
  localparam logic [9:0] ADDR_SCAN_STATUS = 10'h00C;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int RESOLUTION_SELECT_BIT = 7;
  localparam int CTL_START_BIT = 0;
  localparam int CTL_IRQ_EN_BIT = 1;
  localparam int CTL_MODE_LSB = 2;
  localparam int CTL_FIRST_LSB = 4;
  localparam int CTL_LAST_LSB = 8;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_SCAN_BIT = 1;
  // ------------------------------------------------------------
  // Reset values and widths
  // ------------------------------------------------------------
  localparam logic RESOLUTION_SELECT_RST = 1'b0;
  localparam logic IRQ_ENABLE_RST = 1'b0;
  localparam logic [1:0] MODE_RST = 2'b00;
  localparam logic [2:0] CHANNEL_RST = 3'h0;
  localparam int IRQ_BITS = 2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLOCK_HZ = 50_000_000;
  localparam int CONV_TIME_NS = 2000;
  localparam int CONV_CYCLES = (CONV_TIME_NS * (CLOCK_HZ / 1_000_000)
    + 999) / 1000;
  // ------------------------------------------------------------
  // Modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ARSC_SINGLE_REACT = 2'b00,
    ARSC_SINGLE_NOREACT = 2'b01,
    ARSC_CONTINUOUS = 2'b10,
    ARSC_STOP = 2'b11
  } arsc_mode_e;
endpackage

// file: arsc_sar.sv
// Successive approximation engine, one bit decided per clock.
// Assumes the comparator answers in the same cycle as the trial word.
`timescale 1ns/10ps
module arsc_sar #(
  parameter int WIDTH = 10,
  parameter int SETTLE = 4
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic start,
  // Comparator side
  output logic [WIDTH-1:0] trial,
  input wire logic cmp_above,
  // Result
  output logic [WIDTH-1:0] result,
  output logic done
);
  typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_BITS} arsc_sar_st_e;
  arsc_sar_st_e st_r, st_nxt;
  logic [WIDTH-1:0] word_r, word_nxt;
  logic [WIDTH-1:0] bit_r, bit_nxt;
  logic [7:0] wait_r, wait_nxt;
  logic done_r, done_nxt;

  // Next state of the bit search
  always_comb begin
    st_nxt = st_r;
    word_nxt = word_r;
    bit_nxt = bit_r;
    wait_nxt = wait_r;
    done_nxt = 1'b0;
    case (st_r)
      ST_IDLE: ;
      ST_SETTLE: begin
        if (wait_r == 8'h00) begin
          st_nxt = ST_BITS;
          word_nxt = bit_r;
        end else begin
          wait_nxt = wait_r - 8'h01;
        end
      end
      ST_BITS: begin
        // Keep the bit unless input lies below the trial
        if (!cmp_above) word_nxt = word_r & ~bit_r;
        if (bit_r[0]) begin
          st_nxt = ST_IDLE;
          done_nxt = 1'b1;
        end else begin
          bit_nxt = bit_r >> 1;
          word_nxt = (cmp_above ? word_r : (word_r & ~bit_r)) | (bit_r >> 1);
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    // Start restarts the search from any state, dropping a late done
    if (start) begin
      st_nxt = ST_SETTLE;
      wait_nxt = 8'(SETTLE);
      word_nxt = '0;
      bit_nxt = {1'b1, {(WIDTH-1){1'b0}}};
      done_nxt = 1'b0;
    end
  end

  // Registers of the bit search
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_IDLE;
      word_r <= '0;
      bit_r <= '0;
      wait_r <= 8'h00;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      word_r <= word_nxt;
      bit_r <= bit_nxt;
      wait_r <= wait_nxt;
      done_r <= done_nxt;
    end
  end

  assign trial = word_r;
  assign result = word_r;
  assign done = done_r;
endmodule

// file: arsc_top.sv
// Converter result registers and single-scan sequencer.
// Assumes an AXI4-Lite master and one external comparator shared through channel_sel.
`timescale 1ns/10ps
module arsc_top #(
  parameter int RES_BITS = 10,
  parameter int CHANNELS = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog front end
  output logic [2:0] channel_sel,
  output logic [RES_BITS-1:0] dac_trial,
  input wire logic cmp_above,
  // Completion request and interrupt
  output logic transfer_req,
  output logic irq
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [1:0] {SC_HALT, SC_CONVERT, SC_PAUSE} arsc_scan_e;
  arsc_scan_e scan_r, scan_nxt;
  logic resolution_select_r, resolution_select_nxt;
  logic completion_irq_enable_r, completion_irq_enable_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic [2:0] scan_first_channel_r, scan_first_channel_nxt;
  logic [2:0] scan_last_channel_r, scan_last_channel_nxt;
  logic [2:0] chan_r, chan_nxt;
  logic [15:0] conversion_result_word_r, conversion_result_word_nxt;
  logic [arsc_pkg::IRQ_BITS-1:0] irq_stat_r, irq_stat_nxt;
  logic [arsc_pkg::IRQ_BITS-1:0] irq_mask_r, irq_mask_nxt;
  logic transfer_req_r, transfer_req_nxt;
  logic irq_r, irq_nxt;
  logic sar_start_r, sar_start_nxt;
  // Bus state
  logic aw_held_r, aw_held_nxt;
  logic w_held_r, w_held_nxt;
  logic [9:0] waddr_r, waddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [RES_BITS-1:0] sar_result;
  logic sar_done;
  logic conv_done;
  logic do_write;
  logic [arsc_pkg::IRQ_BITS-1:0] irq_event;

  // Address decode used by the write path
  function automatic logic mapped(input logic [9:0] a);
    mapped = (a == arsc_pkg::ADDR_RESULT_LOW) ||
      (a == arsc_pkg::ADDR_RESULT_HIGH) || (a == arsc_pkg::ADDR_CONTROL) ||
      (a == arsc_pkg::ADDR_IRQ_STATUS) || (a == arsc_pkg::ADDR_IRQ_MASK) ||
      (a == arsc_pkg::ADDR_SCAN_STATUS);
  endfunction

  // ------------------------------------------------------------
  // Conversion engine
  // ------------------------------------------------------------
  arsc_sar #(
    .WIDTH(RES_BITS),
    .SETTLE(arsc_pkg::CONV_CYCLES)
  ) u_sar (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(sar_start_r),
    .trial(dac_trial),
    .cmp_above(cmp_above),
    .result(sar_result),
    .done(sar_done)
  );

  // ------------------------------------------------------------
  // Write channel handling
  // ------------------------------------------------------------
  assign do_write = aw_held_r && w_held_r && !bvalid_r;

  // Next values of the write and read slave
  always_comb begin
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_awvalid && !aw_held_r) begin
      aw_held_nxt = 1'b1;
      waddr_nxt = {s_axi_awaddr[9:2], 2'b00};
    end
    if (s_axi_wvalid && !w_held_r) begin
      w_held_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (do_write) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = mapped(waddr_r) ? arsc_pkg::RESP_OKAY :
        arsc_pkg::RESP_SLVERR;
    end
    if (bvalid_r && s_axi_bready) bvalid_nxt = 1'b0;
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = arsc_pkg::RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      case ({s_axi_araddr[9:2], 2'b00})
        arsc_pkg::ADDR_RESULT_LOW:
          rdata_nxt[7:0] = conversion_result_word_r[7:0];
        arsc_pkg::ADDR_RESULT_HIGH: begin
          // Upper byte: select bit plus two result bits
          rdata_nxt[arsc_pkg::RESOLUTION_SELECT_BIT] = resolution_select_r;
          rdata_nxt[1:0] = conversion_result_word_r[9:8];
        end
        arsc_pkg::ADDR_CONTROL: begin
          rdata_nxt[arsc_pkg::CTL_IRQ_EN_BIT] = completion_irq_enable_r;
          rdata_nxt[arsc_pkg::CTL_MODE_LSB +: 2] = mode_r;
          rdata_nxt[arsc_pkg::CTL_FIRST_LSB +: 3] = scan_first_channel_r;
          rdata_nxt[arsc_pkg::CTL_LAST_LSB +: 3] = scan_last_channel_r;
        end
        arsc_pkg::ADDR_IRQ_STATUS: rdata_nxt[1:0] = irq_stat_r;
        arsc_pkg::ADDR_IRQ_MASK: rdata_nxt[1:0] = irq_mask_r;
        arsc_pkg::ADDR_SCAN_STATUS: begin
          rdata_nxt[0] = (scan_r != SC_HALT);
          rdata_nxt[6:4] = chan_r;
        end
        default: rresp_nxt = arsc_pkg::RESP_SLVERR;
      endcase
    end
    if (rvalid_r && s_axi_rready) rvalid_nxt = 1'b0;
  end

  // Registers of the bus slave
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      waddr_r <= 10'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'h0;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // ------------------------------------------------------------
  // Scan sequencer, result and interrupts
  // ------------------------------------------------------------
  // Completion of the running conversion; a stale one is dropped on restart
  assign conv_done = sar_done && scan_r == SC_CONVERT && !sar_start_r;
  assign irq_event = {conv_done && chan_r == scan_last_channel_r, conv_done};

  // Next values of the converter control
  always_comb begin
    scan_nxt = scan_r;
    resolution_select_nxt = resolution_select_r;
    completion_irq_enable_nxt = completion_irq_enable_r;
    mode_nxt = mode_r;
    scan_first_channel_nxt = scan_first_channel_r;
    scan_last_channel_nxt = scan_last_channel_r;
    chan_nxt = chan_r;
    conversion_result_word_nxt = conversion_result_word_r;
    irq_mask_nxt = irq_mask_r;
    irq_stat_nxt = irq_stat_r;
    transfer_req_nxt = 1'b0;
    sar_start_nxt = 1'b0;
    if (do_write && waddr_r == arsc_pkg::ADDR_RESULT_HIGH && wstrb_r[0])
      resolution_select_nxt =
        wdata_r[arsc_pkg::RESOLUTION_SELECT_BIT];
    if (do_write && waddr_r == arsc_pkg::ADDR_IRQ_MASK && wstrb_r[0])
      irq_mask_nxt = wdata_r[1:0];
    if (do_write && waddr_r == arsc_pkg::ADDR_IRQ_STATUS && wstrb_r[0])
      irq_stat_nxt = irq_stat_r & ~wdata_r[1:0];
    irq_stat_nxt = irq_stat_nxt | irq_event; // Set wins over clear
    case (scan_r)
      SC_HALT: ;
      SC_PAUSE: begin
        sar_start_nxt = 1'b1;
        scan_nxt = SC_CONVERT;
      end
      SC_CONVERT: begin
        if (conv_done) begin
          // Overwrite result atomically
          if (resolution_select_r)
            conversion_result_word_nxt = {8'h00,
              sar_result[RES_BITS-1 -: 8]};
          else
            conversion_result_word_nxt = 16'(sar_result);
          transfer_req_nxt = 1'b1;
          if (chan_r == scan_last_channel_r) begin
            scan_nxt = SC_HALT;
          end else begin
            chan_nxt = chan_r + 3'h1; // Wraps 7 to 0
            scan_nxt = SC_PAUSE;
          end
        end
      end
      default: scan_nxt = SC_HALT;
    endcase
    // Control write after the sequencer so a restart wins over a completion
    if (do_write && waddr_r == arsc_pkg::ADDR_CONTROL &&
        wstrb_r[1:0] == 2'h3) begin
      completion_irq_enable_nxt = wdata_r[arsc_pkg::CTL_IRQ_EN_BIT];
      mode_nxt = wdata_r[arsc_pkg::CTL_MODE_LSB +: 2];
      scan_first_channel_nxt = wdata_r[arsc_pkg::CTL_FIRST_LSB +: 3];
      scan_last_channel_nxt = wdata_r[arsc_pkg::CTL_LAST_LSB +: 3];
      // Start; every written mode but single with re-activation ignores it while busy
      if (wdata_r[arsc_pkg::CTL_START_BIT] && (scan_r == SC_HALT ||
          wdata_r[arsc_pkg::CTL_MODE_LSB +: 2] ==
          arsc_pkg::ARSC_SINGLE_REACT)) begin
        scan_nxt = SC_PAUSE;
        chan_nxt = wdata_r[arsc_pkg::CTL_FIRST_LSB +: 3];
      end
    end
  end

  // Interrupt output: status masked by both enables
  always_comb begin
    irq_nxt = completion_irq_enable_r &&
      |(irq_stat_nxt & irq_mask_nxt);
  end

  // Registers of the converter control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_r <= SC_HALT;
      resolution_select_r <= arsc_pkg::RESOLUTION_SELECT_RST;
      completion_irq_enable_r <= arsc_pkg::IRQ_ENABLE_RST;
      mode_r <= arsc_pkg::MODE_RST;
      scan_first_channel_r <= arsc_pkg::CHANNEL_RST;
      scan_last_channel_r <= arsc_pkg::CHANNEL_RST;
      chan_r <= arsc_pkg::CHANNEL_RST;
      conversion_result_word_r <= 16'h0000;
      irq_mask_r <= 2'h0;
      irq_stat_r <= 2'h0;
      transfer_req_r <= 1'b0;
      irq_r <= 1'b0;
      sar_start_r <= 1'b0;
    end else begin
      scan_r <= scan_nxt;
      resolution_select_r <= resolution_select_nxt;
      completion_irq_enable_r <= completion_irq_enable_nxt;
      mode_r <= mode_nxt;
      scan_first_channel_r <= scan_first_channel_nxt;
      scan_last_channel_r <= scan_last_channel_nxt;
      chan_r <= chan_nxt;
      conversion_result_word_r <= conversion_result_word_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq_stat_r <= irq_stat_nxt;
      transfer_req_r <= transfer_req_nxt;
      irq_r <= irq_nxt;
      sar_start_r <= sar_start_nxt;
    end
  end

  // ------------------------------------------------------------
  // Output drive
  // ------------------------------------------------------------
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready = !w_held_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign channel_sel = chan_r;
  assign transfer_req = transfer_req_r;
  assign irq = irq_r;
endmodule

// file: arsc_top_sva.sv
// Port checker for the converter result and scan block.
// Assumes it is bound to arsc_top and sees only its ports.
`timescale 1ns/10ps
module arsc_top_sva (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter outputs
  input wire logic [2:0] channel_sel,
  input wire logic transfer_req,
  input wire logic irq
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reset_clear_a: assert property ($rose(aresetn) |-> !irq
    && !transfer_req && channel_sel == 3'h0 && !s_axi_bvalid
    && !s_axi_rvalid) else $error("outputs not cleared by reset");
  one_pulse_a: assert property (transfer_req |=>
    !transfer_req [*8]) else $error("completion request not one pulse");
  write_lat_a: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read data late");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while data pending");
  high_zero_a: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr[9:2] == arsc_pkg::IDX_RESULT_HIGH
    |=> s_axi_rdata[6:2] == 5'h00) else $error("upper bits not zero");
  unmapped_a: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr[31:10] == 22'h0 && s_axi_araddr[9:4] != 6'h00
    && s_axi_araddr[9:2] != arsc_pkg::IDX_RESULT_LOW
    && s_axi_araddr[9:2] != arsc_pkg::IDX_RESULT_HIGH
    |=> s_axi_rresp == arsc_pkg::RESP_SLVERR) else $error("no error resp");
endmodule

bind arsc_top arsc_top_sva u_sva (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .channel_sel, .transfer_req, .irq);

// file: arsc_afe_model.sv
// Model of the eight analog inputs and the trial comparator.
// Assumes one fixed level per channel, given by the bench.
`timescale 1ns/10ps
module arsc_afe_model (
  // Converter side
  input wire logic [2:0] channel_sel,
  input wire logic [9:0] dac_trial,
  output logic cmp_above,
  // Analog levels
  input wire logic [9:0] level [8]
);
  // Selected input at or above the trial word
  assign cmp_above = level[channel_sel] >= dac_trial;
endmodule

// file: arsc_top_tb.sv
// Self-checking bench for the converter result and scan block.
// Assumes arsc_top with its default parameters.
`timescale 1ns/10ps
module arsc_top_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [31:0] s_axi_araddr = 32'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [2:0] channel_sel;
  logic [9:0] dac_trial;
  logic cmp_above;
  logic transfer_req;
  logic irq;
  logic [9:0] lv [8] = '{10'h3A5, 10'h001, 10'h2C6, 10'h3FF, 10'h000,
    10'h1B7, 10'h2E9, 10'h15A};
  logic [2:0] ch_d = 3'h0;
  logic s10 = 1'b0;
  logic ien = 1'b0;
  int log[$];
  int n_errors = 0;
  int check_count = 0;
  logic [31:0] d;
  logic [1:0] r;

  // ------------------------------------------------------------
  // Design, analog model and clock
  // ------------------------------------------------------------
  arsc_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .channel_sel,
    .dac_trial, .cmp_above, .transfer_req, .irq);
  arsc_afe_model u_afe (.channel_sel, .dac_trial, .cmp_above,
    .level(lv));

  // 50 MHz clock
  initial begin
    forever #10 aclk = ~aclk;
  end

  // Channel of each completed conversion
  always @(posedge aclk) begin
    if (transfer_req === 1'b1)
      log.push_back(ch_d);
    ch_d <= channel_sel;
  end

  // ------------------------------------------------------------
  // Bus tasks and comparison
  // ------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    if (n >= 200)
      n_errors++;
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask

  task automatic rd(input logic [31:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    if (n >= 200)
      n_errors++;
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  // One scan, then the channel order and request count
  task automatic scan(input int f, input int l, input int m);
    int c;
    int n;
    int q[$];
    log.delete();
    wr({22'h0, arsc_pkg::ADDR_CONTROL}, {21'h0, l[2:0], 1'b0, f[2:0],
      m[1:0], ien, 1'b1});
    chk("start resp", {30'h0, arsc_pkg::RESP_OKAY}, {30'h0, r});
    n = 0;
    do begin
      rd({22'h0, arsc_pkg::ADDR_SCAN_STATUS});
      n++;
    end while (d[0] !== 1'b0 && n < 2000);
    if (n >= 2000)
      n_errors++;
    rd({22'h0, arsc_pkg::ADDR_CONTROL});
    chk("control", {21'h0, l[2:0], 1'b0, f[2:0], m[1:0], ien, 1'b0},
      d);
    c = f;
    repeat (8) begin
      q.push_back(c);
      if (c == l)
        break;
      c = (c + 1) % 8;
    end
    chk("request count", q.size(), log.size());
    foreach (q[i])
      chk("scan channel", q[i], log[i]);
  endtask

  // Result registers against the level of channel l
  task automatic res(input int l);
    rd({22'h0, arsc_pkg::ADDR_RESULT_LOW});
    chk("result low", s10 ? lv[l][9:2] : lv[l][7:0], d);
    rd({22'h0, arsc_pkg::ADDR_RESULT_HIGH});
    chk("result high", {s10, 5'h0, s10 ? 2'b00 : lv[l][9:8]}, d);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd({22'h0, arsc_pkg::ADDR_RESULT_HIGH});
    chk("select reset", 32'h0, {31'h0, d[7]});
    chk("irq reset", 32'h0, {31'h0, irq});
    $display("test reset done");
    wr({22'h0, arsc_pkg::ADDR_IRQ_MASK}, 32'h3);
    scan(1, 3, 0);
    res(3);
    repeat (50) @(posedge aclk);
    res(3);
    chk("irq disabled", 32'h0, {31'h0, irq});
    scan(2, 2, 0);
    res(2);
    scan(6, 3, 0);
    res(3);
    $display("test ten bit done");
    wr({22'h0, arsc_pkg::ADDR_RESULT_HIGH}, 32'h80);
    s10 = 1'b1;
    scan(5, 5, 0);
    res(5);
    for (int m = 0; m < 4; m++) begin
      scan(4, 4, m);
      res(4);
    end
    wr({22'h0, arsc_pkg::ADDR_CONTROL}, 32'h701);
    repeat (60) @(posedge aclk);
    scan(5, 5, 0);
    res(5);
    $display("test eight bit done");
    wr({22'h0, arsc_pkg::ADDR_IRQ_STATUS}, 32'h3);
    ien = 1'b1;
    scan(0, 0, 0);
    repeat (3) @(posedge aclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr({22'h0, arsc_pkg::ADDR_IRQ_MASK}, 32'h0);
    repeat (3) @(posedge aclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr({22'h0, arsc_pkg::ADDR_IRQ_MASK}, 32'h3);
    repeat (3) @(posedge aclk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr({22'h0, arsc_pkg::ADDR_IRQ_STATUS}, 32'h3);
    repeat (3) @(posedge aclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    wr(32'h10, 32'h0);
    chk("write unmapped", {30'h0, arsc_pkg::RESP_SLVERR}, {30'h0, r});
    rd(32'h10);
    chk("read unmapped", {30'h0, arsc_pkg::RESP_SLVERR}, {30'h0, r});
    $display("test unmapped done");
    results();
  end

  // Watchdog well beyond the expected run
  initial begin
    repeat (40000) @(posedge aclk);
    n_errors++;
    results();
  end
endmodule
